/* src/dsrp_regs.v */
// Ramp step/rate, profile bank and RAM data port registers
// Summary of operation
// - Ramp step and rate outputs apply only while ramp generator enable is set
// - Eight-byte ramp step-size register at address 0x0c
// - Step register: decrement step in upper half, increment step in lower
// - Four-byte ramp-rate register at address 0x0d
// - Rate register: upper 16 bits decrement interval, lower increment interval
// - Eight 64-bit profile registers at addresses 0x0e through 0x15
// - RAM enable set makes every profile a RAM playback profile
// - Single-tone view only when RAM, ramp and parallel enables clear
// - Active profile comes from the three external profile-select inputs
// - RAM enabled and internal profile field nonzero: automatic profile select
// - Tone view: amplitude 61:48, phase 47:32, frequency 31:0, top bits unused
// - RAM view: address step rate in bits 55:40
// - RAM view: end address 39:30, start address 23:14
// - No-dwell-high clear in ramp-up: sequencer halts at end address
// - No-dwell-high set in ramp-up: jump to start address then halt
// - Zero-crossing bit takes effect only in direct-switch RAM mode
// - RAM data port writes 32-bit words, count from start/end, 1..1024
`include "dsrp_defines.vh"
module dsrp_regs (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [4:0]  wr_addr,
  input  wire [63:0] wr_data,
  input  wire        rd_en,
  input  wire [4:0]  rd_addr,
  output reg  [63:0] rd_data,
  output reg         rd_valid,
  input  wire        io_update,
  input  wire [31:0] control_function_one,
  input  wire [31:0] control_function_two,
  input  wire [2:0]  profile_sel_pin,
  input  wire [2:0]  auto_profile,
  input  wire        ram_ramp_up_mode,
  input  wire        ram_direct_switch_mode,
  input  wire        ram_at_end,
  output reg  [31:0] ramp_dec_step,
  output reg  [31:0] ramp_inc_step,
  output reg  [15:0] ramp_dec_rate,
  output reg  [15:0] ramp_inc_rate,
  output reg  [2:0]  active_profile,
  output reg         tone_view,
  output reg         playback_view,
  output reg  [31:0] frequency_tuning_word,
  output reg  [15:0] phase_offset_word,
  output reg  [13:0] amplitude_scale_factor,
  output reg  [15:0] ram_step_rate,
  output reg  [9:0]  ram_start_addr,
  output reg  [9:0]  ram_end_addr,
  output reg  [2:0]  ram_mode_ctl,
  output reg         ram_zero_cross_en,
  output reg         ram_halt,
  output reg         ram_jump_start,
  input  wire [9:0]  ram_rd_addr,
  output wire [31:0] ram_rd_data,
  output wire        ram_load_done
);
  // Buffered (shadow) and active copies of the step, rate and profile registers
  reg  [63:0] step_buf_r;
  reg  [63:0] step_r;
  reg  [31:0] rate_buf_r;
  reg  [31:0] rate_r;
  wire [63:0] prof_buf [0:7];
  wire [63:0] prof_act [0:7];
  reg  [2:0]  psel_s1_r;
  reg  [2:0]  psel_s2_r;
  reg  [2:0]  psel_s3_r;
  reg  [2:0]  psel_r;
  reg  [2:0]  sel_nxt;
  reg  [63:0] cur;
  reg  [63:0] rd_nxt;
  wire [4:0]  rd_idx;
  wire [4:0]  wr_idx;
  wire        prof_wr;
  wire [7:0]  prof_wr_dec;
  wire        auto_sel;
  wire        tone_en;
  wire [63:0] load_win;
  wire        ram_en;
  wire        ramp_en;
  wire        par_en;
  wire        ram_wr;
  wire [3:0]  ipc;
  // Field views of the selected profile
  wire [13:0] cur_asf;
  wire [15:0] cur_pow;
  wire [31:0] cur_ftw;
  wire [15:0] cur_step_rate;
  wire [9:0]  cur_end;
  wire [9:0]  cur_start;
  wire        cur_no_dwell;
  wire        cur_zero_cross;
  wire [2:0]  cur_mode;

  assign ram_en   = control_function_one[`DSRP_CF1_RAM_EN];
  assign ramp_en  = control_function_two[`DSRP_CF2_RAMP_EN];
  assign par_en   = control_function_two[`DSRP_CF2_PAR_EN];
  assign ipc      = control_function_one[`DSRP_CF1_IPC_HI:`DSRP_CF1_IPC_LO];
  assign auto_sel = ram_en && (ipc != 4'h0);
  assign tone_en  = !ram_en && !ramp_en && !par_en;
  // Slot decode as a one-hot strobe, one bit per profile slot
  assign prof_wr  = wr_en && (wr_addr >= `DSRP_ADDR_PROF0) &&
                    (wr_addr <= `DSRP_ADDR_PROF7);
  assign wr_idx   = wr_addr - `DSRP_ADDR_PROF0;
  assign rd_idx   = rd_addr - `DSRP_ADDR_PROF0;
  assign prof_wr_dec = prof_wr ? (8'h01 << wr_idx[2:0]) : 8'h00;
  // RAM port is unbuffered: each word up to the window end goes straight into the memory
  assign ram_wr   = wr_en && (wr_addr == `DSRP_ADDR_RAM);

  // Shadow writes from the serial port
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_buf_r <= `DSRP_RST_64;
      rate_buf_r <= `DSRP_RST_32;
    end else if (wr_en) begin
      if (wr_addr == `DSRP_ADDR_STEP)
        step_buf_r <= wr_data;
      if (wr_addr == `DSRP_ADDR_RATE)
        rate_buf_r <= wr_data[31:0];
    end
  end

  // Update event copies shadows into the active registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_r <= `DSRP_RST_64;
      rate_r <= `DSRP_RST_32;
    end else if (io_update) begin
      step_r <= step_buf_r;
      rate_r <= rate_buf_r;
    end
  end

  // One shadow/active pair per slot, so no two processes share a variable
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_prof
      reg [63:0] buf_r;
      reg [63:0] act_r;
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          buf_r <= `DSRP_RST_64;
          act_r <= `DSRP_RST_64;
        end else begin
          if (prof_wr_dec[g])
            buf_r <= wr_data;
          if (io_update)
            act_r <= buf_r;
        end
      end
      assign prof_buf[g] = buf_r;
      assign prof_act[g] = act_r;
    end
  endgenerate

  // Profile pins are asynchronous: three stages, change taken when last two agree
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      psel_s1_r <= 3'h0;
      psel_s2_r <= 3'h0;
      psel_s3_r <= 3'h0;
      psel_r    <= 3'h0;
    end else begin
      psel_s1_r <= profile_sel_pin;
      psel_s2_r <= psel_s1_r;
      psel_s3_r <= psel_s2_r;
      if (psel_s2_r == psel_s3_r)
        psel_r <= psel_s3_r;
    end
  end

  // Automatic selection overrides the pins only in RAM playback
  always @* begin
    if (auto_sel)
      sel_nxt = auto_profile;
    else
      sel_nxt = psel_r;
    cur = prof_act[sel_nxt];
  end

  assign cur_asf        = cur[61:48];
  assign cur_pow        = cur[47:32];
  assign cur_ftw        = cur[31:0];
  assign cur_step_rate  = cur[55:40];
  assign cur_end        = cur[39:30];
  assign cur_start      = cur[23:14];
  assign cur_no_dwell   = cur[5];
  assign cur_zero_cross = cur[3];
  assign cur_mode       = cur[2:0];

  // Ramp gating holds the ramp engine idle rather than running on stale steps
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ramp_dec_step <= 32'h00000000;
      ramp_inc_step <= 32'h00000000;
      ramp_dec_rate <= 16'h0000;
      ramp_inc_rate <= 16'h0000;
    end else if (ramp_en) begin
      ramp_dec_step <= step_r[63:32];
      ramp_inc_step <= step_r[31:0];
      ramp_dec_rate <= rate_r[31:16];
      ramp_inc_rate <= rate_r[15:0];
    end else begin
      ramp_dec_step <= 32'h00000000;
      ramp_inc_step <= 32'h00000000;
      ramp_dec_rate <= 16'h0000;
      ramp_inc_rate <= 16'h0000;
    end
  end

  // Selected slot and which view of the bank applies
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_profile <= 3'h0;
      tone_view      <= 1'b0;
      playback_view  <= 1'b0;
    end else begin
      active_profile <= sel_nxt;
      tone_view      <= tone_en;
      playback_view  <= ram_en;
    end
  end

  // Tone fields read zero outside the tone view
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      amplitude_scale_factor <= 14'h0000;
      phase_offset_word      <= 16'h0000;
      frequency_tuning_word  <= 32'h00000000;
    end else if (tone_en) begin
      amplitude_scale_factor <= cur_asf;
      phase_offset_word      <= cur_pow;
      frequency_tuning_word  <= cur_ftw;
    end else begin
      amplitude_scale_factor <= 14'h0000;
      phase_offset_word      <= 16'h0000;
      frequency_tuning_word  <= 32'h00000000;
    end
  end

  // Playback fields read zero unless RAM is enabled
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ram_step_rate     <= 16'h0000;
      ram_end_addr      <= 10'h000;
      ram_start_addr    <= 10'h000;
      ram_mode_ctl      <= 3'h0;
      ram_zero_cross_en <= 1'b0;
      ram_halt          <= 1'b0;
      ram_jump_start    <= 1'b0;
    end else if (ram_en) begin
      ram_step_rate     <= cur_step_rate;
      ram_end_addr      <= cur_end;
      ram_start_addr    <= cur_start;
      ram_mode_ctl      <= cur_mode;
      ram_zero_cross_en <= cur_zero_cross && ram_direct_switch_mode;
      ram_halt          <= ram_ramp_up_mode && ram_at_end && !cur_no_dwell;
      ram_jump_start    <= ram_ramp_up_mode && ram_at_end && cur_no_dwell;
    end else begin
      ram_step_rate     <= 16'h0000;
      ram_end_addr      <= 10'h000;
      ram_start_addr    <= 10'h000;
      ram_mode_ctl      <= 3'h0;
      ram_zero_cross_en <= 1'b0;
      ram_halt          <= 1'b0;
      ram_jump_start    <= 1'b0;
    end
  end

  // Readback returns the buffered contents, which is what the host wrote
  always @* begin
    rd_nxt = 64'h0000000000000000;
    case (rd_addr)
      `DSRP_ADDR_STEP: rd_nxt = step_buf_r;
      `DSRP_ADDR_RATE: rd_nxt = {32'h00000000, rate_buf_r};
      `DSRP_ADDR_RAM:  rd_nxt = {32'h00000000, ram_rd_data};
      default: begin
        if (rd_addr >= `DSRP_ADDR_PROF0 && rd_addr <= `DSRP_ADDR_PROF7)
          rd_nxt = prof_buf[rd_idx[2:0]];
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data  <= 64'h0000000000000000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_nxt;
    end
  end

  // Memory load restarts on every update, with the window taken from the pin-selected profile's buffered copy
  assign load_win = prof_buf[psel_r];
  dsrp_ram_words u_ram (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (io_update),
    .start_addr (load_win[23:14]),
    .end_addr   (load_win[39:30]),
    .wr_en      (ram_wr),
    .wr_data    (wr_data[31:0]),
    .rd_addr    (ram_rd_addr),
    .rd_data    (ram_rd_data),
    .load_done  (ram_load_done)
  );
endmodule

/* include/dsrp_defines.vh */
// Register offsets, field positions, reset values for the ramp/profile/RAM register slice
`ifndef DSRP_DEFINES_VH
`define DSRP_DEFINES_VH
`define DSRP_ADDR_STEP      5'h0c
`define DSRP_ADDR_RATE      5'h0d
`define DSRP_ADDR_PROF0     5'h0e
`define DSRP_ADDR_PROF7     5'h15
`define DSRP_ADDR_RAM       5'h16
`define DSRP_CF1_RAM_EN     31
`define DSRP_CF1_IPC_HI     20
`define DSRP_CF1_IPC_LO     17
`define DSRP_CF2_RAMP_EN    19
`define DSRP_CF2_PAR_EN     4
`define DSRP_RST_64         64'h0000000000000000
`define DSRP_RST_32         32'h00000000
`define DSRP_RAM_DEPTH      1024
`endif

/* src/dsrp_ram_words.v */
// Waveform memory: 1024 x 32 words in flip-flops, written in sequence
`include "dsrp_defines.vh"
module dsrp_ram_words (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        load,
  input  wire [9:0]  start_addr,
  input  wire [9:0]  end_addr,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  input  wire [9:0]  rd_addr,
  output reg  [31:0] rd_data,
  output wire        load_done
);
  reg [31:0] mem [0:`DSRP_RAM_DEPTH-1];
  reg [9:0]  wptr_r;
  reg        done_r;
  assign load_done = done_r;
  // Pointer runs start to end; one word minimum when start equals end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wptr_r <= 10'h000;
      done_r <= 1'b0;
    end else if (load) begin
      // A word arriving with the update lands at the new start, not the old pointer
      wptr_r <= (wr_en && start_addr != end_addr) ? start_addr + 10'h001 : start_addr;
      done_r <= wr_en && (start_addr == end_addr);
    end else if (wr_en && !done_r) begin
      if (wptr_r == end_addr)
        done_r <= 1'b1;
      else
        wptr_r <= wptr_r + 10'h001;
    end
  end
  always @(posedge clk_sys) begin
    if (wr_en && load)
      mem[start_addr] <= wr_data;
    else if (wr_en && !done_r)
      mem[wptr_r] <= wr_data;
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      rd_data <= 32'h00000000;
    else
      rd_data <= mem[rd_addr];
  end
endmodule

/* testbench/dsrp_host.sv */
// Host model driving register access, updates and profile pins
module dsrp_host (
  input  wire         clk_sys,
  output logic        wr_en,
  output logic [4:0]  wr_addr,
  output logic [63:0] wr_data,
  output logic        rd_en,
  output logic [4:0]  rd_addr,
  output logic        io_update,
  output logic [2:0]  profile_sel_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr_en, wr_addr, wr_data, rd_en, rd_addr, io_update, profile_sel_pin} = '0;
  task automatic wr(input logic [4:0] a, input logic [63:0] d);
    @(negedge clk_sys);
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    @(negedge clk_sys);
    // Released bus shows the inverse, never a stale copy
    {wr_en, wr_data} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [4:0] a);
    @(negedge clk_sys);
    {rd_en, rd_addr} = {1'b1, a};
    @(negedge clk_sys);
    {rd_en, rd_addr} = {1'b0, ~a};
  endtask
  task automatic upd;
    @(negedge clk_sys);
    io_update = 1'b1;
    @(negedge clk_sys);
    io_update = 1'b0;
  endtask
  task automatic sel(input logic [2:0] p);
    @(negedge clk_sys);
    profile_sel_pin = p;
  endtask
endmodule

/* testbench/dsrp_regs_props.sv */
// Assertions for the ramp, profile and RAM port register slice
module dsrp_regs_props (
  input wire        clk_sys,
  input wire        rst,
  input wire        rd_en,
  input wire        rd_valid,
  input wire [31:0] control_function_one,
  input wire [31:0] control_function_two,
  input wire [2:0]  profile_sel_pin,
  input wire [2:0]  auto_profile,
  input wire        ram_ramp_up_mode,
  input wire        ram_at_end,
  input wire [31:0] ramp_inc_step,
  input wire [2:0]  active_profile,
  input wire        tone_view,
  input wire        playback_view,
  input wire [31:0] frequency_tuning_word,
  input wire        ram_halt,
  input wire        ram_jump_start
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire ram  = control_function_one[31];
  wire aut  = ram && control_function_one[20:17] != 4'h0;
  wire ramp = control_function_two[19];
  wire tone = !ram && !ramp && !control_function_two[4];
  property p_rd; rd_en |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_ramp; (!ramp)[*2] |-> ramp_inc_step == 32'h0; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step leaks");
  property p_ram; ram[*3] |-> playback_view && !tone_view; endproperty
  a_ram: assert property (p_ram) else $error("not playback");
  property p_tone; (!ram && $stable(control_function_two))[*3] |-> tone_view == tone; endproperty
  a_tone: assert property (p_tone) else $error("tone view wrong");
  property p_ftw; (!tone_view)[*2] |-> frequency_tuning_word == 32'h0; endproperty
  a_ftw: assert property (p_ftw) else $error("tone word leaks");
  // Pins pass a synchroniser, so allow eight quiet cycles
  property p_pin; ($stable(profile_sel_pin) && !aut)[*8] |-> active_profile == profile_sel_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("pin profile wrong");
  property p_auto; (aut && $stable(auto_profile))[*3] |-> active_profile == auto_profile;
  endproperty
  a_auto: assert property (p_auto) else $error("auto profile wrong");
  property p_end; ram_halt || ram_jump_start |-> $past(ram_ramp_up_mode) && $past(ram_at_end);
  endproperty
  a_end: assert property (p_end) else $error("halt without end");
  c_rd: cover property (rd_valid);
  c_tone: cover property (tone_view);
  c_play: cover property (playback_view && ram_halt);
endmodule
bind dsrp_regs dsrp_regs_props dsrp_regs_props_i (.*);

/* testbench/dsrp_regs_tb_top.sv */
// Self-checking bench for the ramp, profile and RAM port register slice
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module dsrp_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wr_en, rd_en, io_update, rd_valid, tone_view, playback_view;
  logic ram_zero_cross_en, ram_halt, ram_jump_start, ram_load_done;
  logic ram_ramp_up_mode = 1'b0, ram_direct_switch_mode = 1'b0, ram_at_end = 1'b0;
  logic [4:0] wr_addr, rd_addr;
  logic [63:0] wr_data, rd_data, step, want, exp_q[$], prof[8];
  logic [31:0] control_function_one = 32'h0, control_function_two = 32'h0, rate;
  logic [31:0] ramp_dec_step, ramp_inc_step, frequency_tuning_word, ram_rd_data;
  logic [15:0] ramp_dec_rate, ramp_inc_rate, phase_offset_word, ram_step_rate;
  logic [2:0] profile_sel_pin, active_profile, ram_mode_ctl, auto_profile = 3'h0;
  logic [13:0] amplitude_scale_factor;
  logic [9:0] ram_start_addr, ram_end_addr, ram_rd_addr = 10'h0;
  int miscompares = 0, total_checks = 0;
  dsrp_regs dsrp_regs_i (.*);
  dsrp_host dsrp_host_i (.*);
  always #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      want = exp_q.pop_front();
      `CK(rd_data, want);
    end
  end
  task final_report;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  initial begin
    #20us;
    miscompares++;
    final_report();
  end
  initial begin
    void'($urandom(87824));
    step = {$urandom, $urandom};
    rate = $urandom;
    for (int i = 0; i < 8; i++) prof[i] = {$urandom, $urandom};
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    dsrp_host_i.wr(5'h0c, step);
    dsrp_host_i.wr(5'h0d, {32'h0, rate});
    for (int i = 0; i < 8; i++) dsrp_host_i.wr(5'(14 + i), prof[i]);
    // Last entry is an unmapped address, which reads as zero
    for (int i = 0; i < 11; i++) begin
      exp_q.push_back(i < 8 ? prof[i] : i == 8 ? step : i == 9 ? {32'h0, rate} : 64'h0);
      dsrp_host_i.rd(i < 8 ? 5'(14 + i) : i == 8 ? 5'h0c : i == 9 ? 5'h0d : 5'h1f);
    end
    dsrp_host_i.upd();
    control_function_two = 32'h0008_0000;
    wt(4);
    `CK({ramp_dec_step, ramp_inc_step}, step);
    `CK({ramp_dec_rate, ramp_inc_rate}, rate);
    control_function_two = 32'h10;
    wt(4);
    `CK({tone_view, ramp_inc_step}, 33'h0);
    control_function_two = 32'h0;
    for (int p = 0; p < 8; p++) begin
      dsrp_host_i.sel(3'(p));
      wt(8);
      `CK({amplitude_scale_factor, phase_offset_word, frequency_tuning_word}, prof[p][61:0]);
      `CK({tone_view, active_profile}, {1'b1, 3'(p)});
    end
    control_function_one = 32'h8000_0000;
    {ram_ramp_up_mode, ram_direct_switch_mode, ram_at_end} = 3'h7;
    for (int p = 0; p < 8; p++) begin
      dsrp_host_i.sel(3'(p));
      wt(8);
      `CK({playback_view, ram_step_rate, ram_end_addr}, {1'b1, prof[p][55:30]});
      `CK({ram_start_addr, ram_mode_ctl}, {prof[p][23:14], prof[p][2:0]});
      `CK({ram_jump_start, ram_halt, ram_zero_cross_en}, {prof[p][5], ~prof[p][5], prof[p][3]});
    end
    {ram_ramp_up_mode, ram_direct_switch_mode, ram_at_end} = 3'h4;
    wt(2);
    `CK({ram_jump_start, ram_halt, ram_zero_cross_en}, 3'h0);
    control_function_one = 32'h8002_0000;
    auto_profile = 3'h5;
    wt(6);
    `CK(active_profile, 3'h5);
    control_function_one = 32'h0;
    dsrp_host_i.sel(3'h0);
    // Window of three words, start 2 and end 4
    dsrp_host_i.wr(5'h0e, 64'h0000_0001_0000_8000);
    wt(8);
    `CK(frequency_tuning_word, prof[0][31:0]);
    dsrp_host_i.upd();
    wt(4);
    `CK(frequency_tuning_word, 32'h8000);
    for (int i = 0; i < 4; i++) dsrp_host_i.wr(5'h16, 64'(160 + i));
    `CK(ram_load_done, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ram_rd_addr = 10'(2 + i);
      wt(2);
      `CK(ram_rd_data, 32'(160 + i));
    end
    final_report();
  end
endmodule
